// ==== verilog/dsd_pkg.sv ====
// Constants, types and carriers shared by the data-space address decoder.
package dsd_pkg;

    // Data-space map boundaries.
    localparam logic [15:0] DSD_REG_HI    = 16'h001F;
    localparam logic [15:0] DSD_IO_LO     = 16'h0020;
    localparam logic [15:0] DSD_IO_HI     = 16'h005F;
    localparam logic [15:0] DSD_EXT_LO    = 16'h0060;
    localparam logic [15:0] DSD_EXT_HI    = 16'h00FF;
    localparam logic [15:0] DSD_SRAM_BASE = 16'h0100;
    localparam int          DSD_SRAM_BYTES = 4096;

    // I/O-space conventions: offset into data space and bit-access limit.
    localparam logic [15:0] DSD_IO_TO_DS  = 16'h0020;
    localparam logic [5:0]  DSD_IO_BIT_HI = 6'h1F;

    // Low-byte register index of each pointer pair.
    localparam logic [4:0] DSD_PTR_X_LO = 5'h1A;
    localparam logic [4:0] DSD_PTR_Y_LO = 5'h1C;
    localparam logic [4:0] DSD_PTR_Z_LO = 5'h1E;

    // Local I/O registers, by I/O address.
    localparam int               DSD_GPIO_NUM = 3;
    localparam logic [2:0][5:0]  DSD_GPIO_IO  = {6'h2B, 6'h2A, 6'h1E};
    localparam logic [5:0]       DSD_FLAG_IO  = 6'h16;
    localparam logic [5:0]       DSD_EECTL_IO = 6'h1F;
    localparam int               DSD_EE_RD_BIT = 0;
    localparam int               DSD_EE_WR_BIT = 1;

    // Stall lengths in clock cycles.
    localparam logic [2:0] DSD_EE_RD_STALL = 3'h4;
    localparam logic [2:0] DSD_EE_WR_STALL = 3'h2;

    // Target codes, one-hot.
    localparam logic [4:0] DSD_TGT_NONE = 5'h01;
    localparam logic [4:0] DSD_TGT_REG  = 5'h02;
    localparam logic [4:0] DSD_TGT_IO   = 5'h04;
    localparam logic [4:0] DSD_TGT_EXT  = 5'h08;
    localparam logic [4:0] DSD_TGT_SRAM = 5'h10;

    typedef enum logic [3:0] {
        DSD_OP_LOAD     = 4'h0,
        DSD_OP_STORE    = 4'h1,
        DSD_OP_IO_IN    = 4'h2,
        DSD_OP_IO_OUT   = 4'h3,
        DSD_OP_BIT_SET  = 4'h4,
        DSD_OP_BIT_CLR  = 4'h5,
        DSD_OP_BIT_TEST = 4'h6
    } dsd_op_t;

    typedef enum logic [2:0] {
        DSD_AM_DIRECT  = 3'h0,
        DSD_AM_IND     = 3'h1,
        DSD_AM_PREDEC  = 3'h2,
        DSD_AM_POSTINC = 3'h3,
        DSD_AM_DISP    = 3'h4
    } dsd_mode_t;

    typedef enum logic [1:0] {
        DSD_PTR_X = 2'h0,
        DSD_PTR_Y = 2'h1,
        DSD_PTR_Z = 2'h2
    } dsd_ptr_t;

    typedef enum logic [2:0] {
        DSD_ST_IDLE  = 3'h1,
        DSD_ST_SRAM  = 3'h2,
        DSD_ST_STALL = 3'h4
    } dsd_st_t;

    typedef struct packed {
        logic        valid;
        dsd_op_t     op;
        dsd_mode_t   mode;
        dsd_ptr_t    ptr;
        logic [5:0]  disp;
        logic [15:0] addr;
        logic [5:0]  io_addr;
        logic [2:0]  bit_idx;
        logic [7:0]  wdata;
    } dsd_req_t;

    typedef struct packed {
        logic       valid;
        logic       err;
        logic       bit_state;
        logic [7:0] data;
        logic [4:0] tgt;
    } dsd_rsp_t;

    typedef struct packed {
        logic       valid;
        logic       we;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] wmask;
    } dsd_io_t;

    typedef struct packed {
        dsd_st_t               st;
        logic [2:0]            cnt;
        logic [31:0][7:0]      regs;
        logic [2:0][7:0]       gpio;
        logic [7:0]            flags;
        logic                  ee_rd;
        logic                  ee_wr;
        dsd_rsp_t              rsp;
    } dsd_state_t;

    localparam dsd_state_t DSD_STATE_RST = '{st: DSD_ST_IDLE, default: '0};

    // New value of a plain storage byte under a write or single-bit op.
    function automatic logic [7:0] dsd_merge(input logic [7:0] old, input dsd_op_t op,
                                             input logic [7:0] mask, input logic [7:0] wd);
        logic [7:0] res;
        res = wd;
        if (op == DSD_OP_BIT_SET) begin
            res = old | mask;
        end else if (op == DSD_OP_BIT_CLR) begin
            res = old & ~mask;
        end
        return res;
    endfunction

endpackage

// ==== verilog/dsd_sram.sv ====
// Internal data SRAM with a registered read port.
`timescale 1ns/1ps
module dsd_sram import dsd_pkg::*; #(
    parameter int BYTES = DSD_SRAM_BYTES,
    parameter int AW    = $clog2(BYTES)
) (
    input  wire logic          clock,
    input  wire logic          rst_n,
    input  wire logic          en,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output logic      [7:0]    rdata
);

    logic [7:0] mem [BYTES];
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // The array carries no reset; software must initialise what it reads.
    always_ff @(posedge clock) begin
        if (en && we) begin
            mem[addr] <= wdata;
        end
    end

    // Read data is held until the next enabled read.
    always_comb begin
        rdata_nxt = rdata_r;
        if (en && !we) begin
            rdata_nxt = mem[addr];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata = rdata_r;

endmodule

// ==== verilog/dsd_decoder.sv ====
// Data-space address decoder: register file, I/O spaces, SRAM and EEPROM stall.
`timescale 1ns/1ps
module dsd_decoder import dsd_pkg::*; #(
    parameter int SRAM_BYTES = DSD_SRAM_BYTES
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire dsd_req_t   req,
    output logic            req_ready,
    output dsd_rsp_t        rsp,
    output dsd_io_t         io_bus,
    input  wire logic [7:0] io_rdata,
    input  wire logic [7:0] flag_set_in,
    output logic            ee_read_strobe,
    output logic            ee_write_strobe
);

    localparam int          AW       = $clog2(SRAM_BYTES);
    localparam logic [16:0] SRAM_END = 17'(DSD_SRAM_BASE) + 17'(SRAM_BYTES);

    logic                          rst_meta_r;
    logic                          rst_sync_n;
    dsd_state_t                    s_r;
    dsd_state_t                    s_nxt;
    logic                          take;
    logic                          is_io_op;
    logic                          is_bit_op;
    logic                          is_write;
    logic                          acc_err;
    logic                          wr_ok;
    logic [4:0]                    ptr_lo;
    logic [4:0]                    ptr_hi;
    logic [15:0]                   ptr_val;
    logic [15:0]                   ptr_new;
    logic                          ptr_wb;
    logic [15:0]                   mem_addr;
    logic [15:0]                   ds_io;
    logic [15:0]                   eff_addr;
    logic [15:0]                   sram_off;
    logic                          sram_hit;
    logic [4:0]                    tgt;
    logic [5:0]                    io_idx;
    logic [7:0]                    bit_mask;
    logic [DSD_GPIO_NUM-1:0]       gpio_hit;
    logic [DSD_GPIO_NUM-1:0][7:0]  gpio_wval;
    logic                          flag_hit;
    logic                          eectl_hit;
    logic                          io_local;
    logic [7:0]                    flag_clr;
    logic [7:0]                    ee_val;
    logic                          ee_rd_trig;
    logic                          ee_wr_trig;
    logic [7:0]                    rd_data;
    logic                          sram_go;
    logic [7:0]                    sram_rdata;

    // Reset is released through two flops so that its removal is clean.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_n <= rst_meta_r;
        end
    end

    // New requests are only taken while idle; SRAM and EEPROM stalls hold them off.
    assign req_ready = (s_r.st == DSD_ST_IDLE);
    assign take      = req.valid && req_ready;

    // Operation classes.
    assign is_io_op  = (req.op == DSD_OP_IO_IN) || (req.op == DSD_OP_IO_OUT) ||
                       (req.op == DSD_OP_BIT_SET) || (req.op == DSD_OP_BIT_CLR) ||
                       (req.op == DSD_OP_BIT_TEST);
    assign is_bit_op = (req.op == DSD_OP_BIT_SET) || (req.op == DSD_OP_BIT_CLR) ||
                       (req.op == DSD_OP_BIT_TEST);
    assign is_write  = (req.op == DSD_OP_STORE) || (req.op == DSD_OP_IO_OUT) ||
                       (req.op == DSD_OP_BIT_SET) || (req.op == DSD_OP_BIT_CLR);

    // Pointer pairs live in the top six working registers.
    assign ptr_lo  = (req.ptr == DSD_PTR_X) ? DSD_PTR_X_LO :
                     (req.ptr == DSD_PTR_Y) ? DSD_PTR_Y_LO : DSD_PTR_Z_LO;
    assign ptr_hi  = ptr_lo | 5'h01;
    assign ptr_val = {s_r.regs[ptr_hi], s_r.regs[ptr_lo]};

    // Memory-op address by mode; displacement is six bits so it cannot pass 63.
    always_comb begin
        mem_addr = req.addr;
        ptr_new  = ptr_val;
        case (req.mode)
            DSD_AM_DIRECT: mem_addr = req.addr;
            DSD_AM_IND:    mem_addr = ptr_val;
            DSD_AM_PREDEC: begin
                mem_addr = ptr_val - 16'h0001;
                ptr_new  = ptr_val - 16'h0001;
            end
            DSD_AM_POSTINC: begin
                mem_addr = ptr_val;
                ptr_new  = ptr_val + 16'h0001;
            end
            DSD_AM_DISP:   mem_addr = ptr_val + {10'h000, req.disp};
            default:       mem_addr = req.addr;
        endcase
    end

    // I/O ops carry a six-bit address, so they can never land above 0x5F.
    assign ds_io    = DSD_IO_TO_DS + {10'h000, req.io_addr};
    assign eff_addr = is_io_op ? ds_io : mem_addr;

    // Bit ops above 0x1F and displaced access through X are refused.
    assign acc_err = (is_bit_op && (req.io_addr > DSD_IO_BIT_HI)) ||
                     (!is_io_op && (req.mode == DSD_AM_DISP) && (req.ptr == DSD_PTR_X));
    assign wr_ok   = take && is_write && !acc_err;
    assign ptr_wb  = take && !is_io_op && !acc_err &&
                     ((req.mode == DSD_AM_PREDEC) || (req.mode == DSD_AM_POSTINC));

    // Target decode over the data-space map.
    assign sram_off = eff_addr - DSD_SRAM_BASE;
    assign sram_hit = (eff_addr >= DSD_SRAM_BASE) && ({1'b0, eff_addr} < SRAM_END);
    assign tgt = acc_err                    ? DSD_TGT_NONE :
                 (eff_addr <= DSD_REG_HI)   ? DSD_TGT_REG  :
                 (eff_addr <= DSD_IO_HI)    ? DSD_TGT_IO   :
                 (eff_addr <= DSD_EXT_HI)   ? DSD_TGT_EXT  :
                 sram_hit                   ? DSD_TGT_SRAM : DSD_TGT_NONE;

    // Local I/O registers.
    assign io_idx    = 6'(eff_addr - DSD_IO_TO_DS);
    assign bit_mask  = 8'h01 << req.bit_idx;
    assign flag_hit  = (tgt == DSD_TGT_IO) && (io_idx == DSD_FLAG_IO);
    assign eectl_hit = (tgt == DSD_TGT_IO) && (io_idx == DSD_EECTL_IO);

    // Storage registers hold whatever is written and have no other effect.
    for (genvar k = 0; k < DSD_GPIO_NUM; k++) begin : g_gpio
        assign gpio_hit[k]  = (tgt == DSD_TGT_IO) && (io_idx == DSD_GPIO_IO[k]);
        assign gpio_wval[k] = dsd_merge(s_r.gpio[k], req.op, bit_mask, req.wdata);
    end

    assign io_local = (|gpio_hit) || flag_hit || eectl_hit;

    // A one written to a flag clears it; a single-bit set clears only that flag.
    always_comb begin
        flag_clr = 8'h00;
        if (wr_ok && flag_hit) begin
            if ((req.op == DSD_OP_STORE) || (req.op == DSD_OP_IO_OUT)) begin
                flag_clr = req.wdata;
            end else if (req.op == DSD_OP_BIT_SET) begin
                flag_clr = bit_mask;
            end
        end
    end

    // EEPROM strobe bits are triggers only and read back as zero.
    assign ee_val     = dsd_merge(8'h00, req.op, bit_mask, req.wdata);
    assign ee_rd_trig = wr_ok && eectl_hit && ee_val[DSD_EE_RD_BIT];
    assign ee_wr_trig = wr_ok && eectl_hit && ee_val[DSD_EE_WR_BIT];

    // Read data for everything except SRAM, which answers a cycle later.
    always_comb begin
        rd_data = 8'h00;
        if (tgt == DSD_TGT_REG) begin
            rd_data = s_r.regs[eff_addr[4:0]];
        end else if (flag_hit) begin
            rd_data = s_r.flags;
        end else if (eectl_hit) begin
            rd_data = 8'h00;
        end else if (gpio_hit != '0) begin
            for (int k = 0; k < DSD_GPIO_NUM; k++) begin
                if (gpio_hit[k]) begin
                    rd_data = s_r.gpio[k];
                end
            end
        end else if ((tgt == DSD_TGT_IO) || (tgt == DSD_TGT_EXT)) begin
            rd_data = io_rdata;
        end
    end

    // Peripheral port: bit ops travel with a lane mask so that no other bit is rewritten.
    always_comb begin
        io_bus       = '0;
        io_bus.valid = take && !io_local && ((tgt == DSD_TGT_IO) || (tgt == DSD_TGT_EXT));
        io_bus.we    = is_write;
        io_bus.addr  = eff_addr[7:0];
        io_bus.wdata = req.wdata;
        io_bus.wmask = 8'hFF;
        if (is_bit_op) begin
            io_bus.wmask = bit_mask;
            io_bus.wdata = (req.op == DSD_OP_BIT_SET) ? bit_mask : 8'h00;
        end
    end

    assign sram_go = take && (tgt == DSD_TGT_SRAM);

    dsd_sram #(
        .BYTES (SRAM_BYTES),
        .AW    (AW)
    ) u_sram (
        .clock (clock),
        .rst_n (rst_sync_n),
        .en    (sram_go),
        .we    (is_write),
        .addr  (sram_off[AW-1:0]),
        .wdata (req.wdata),
        .rdata (sram_rdata)
    );

    // Next state: access, pointer write-back, flags and stall sequencing.
    always_comb begin
        s_nxt           = s_r;
        s_nxt.rsp.valid = 1'b0;
        s_nxt.ee_rd     = 1'b0;
        s_nxt.ee_wr     = 1'b0;
        s_nxt.flags     = (s_r.flags & ~flag_clr) | flag_set_in;
        case (s_r.st)
            DSD_ST_IDLE: begin
                if (take) begin
                    s_nxt.rsp.tgt       = tgt;
                    s_nxt.rsp.err       = acc_err;
                    s_nxt.rsp.data      = rd_data;
                    s_nxt.rsp.bit_state = rd_data[req.bit_idx];
                    s_nxt.ee_rd         = ee_rd_trig;
                    s_nxt.ee_wr         = ee_wr_trig;
                    if (sram_go) begin
                        s_nxt.st = DSD_ST_SRAM;
                    end else begin
                        s_nxt.rsp.valid = 1'b1;
                        if (ee_rd_trig) begin
                            s_nxt.st  = DSD_ST_STALL;
                            s_nxt.cnt = DSD_EE_RD_STALL;
                        end else if (ee_wr_trig) begin
                            s_nxt.st  = DSD_ST_STALL;
                            s_nxt.cnt = DSD_EE_WR_STALL;
                        end
                    end
                    if (wr_ok && (tgt == DSD_TGT_REG)) begin
                        s_nxt.regs[eff_addr[4:0]] = req.wdata;
                    end
                    for (int k = 0; k < DSD_GPIO_NUM; k++) begin
                        if (wr_ok && gpio_hit[k]) begin
                            s_nxt.gpio[k] = gpio_wval[k];
                        end
                    end
                    // Pointer write-back wins over a store that hits the pointer itself.
                    if (ptr_wb) begin
                        s_nxt.regs[ptr_lo] = ptr_new[7:0];
                        s_nxt.regs[ptr_hi] = ptr_new[15:8];
                    end
                end
            end
            DSD_ST_SRAM: begin
                s_nxt.rsp.valid     = 1'b1;
                s_nxt.rsp.data      = sram_rdata;
                s_nxt.rsp.bit_state = 1'b0;
                s_nxt.st            = DSD_ST_IDLE;
            end
            DSD_ST_STALL: begin
                s_nxt.cnt = s_r.cnt - 3'h1;
                if (s_r.cnt == 3'h1) begin
                    s_nxt.st = DSD_ST_IDLE;
                end
            end
            default: s_nxt.st = DSD_ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_r <= DSD_STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rsp             = s_r.rsp;
    assign ee_read_strobe  = s_r.ee_rd;
    assign ee_write_strobe = s_r.ee_wr;

    // Checks on routing, latency and stall lengths.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_sync_n);

    sequence sram_wait_s;
        !req_ready ##1 (rsp.valid && (rsp.tgt == DSD_TGT_SRAM));
    endsequence

    sequence stall4_s;
        !req_ready [*4] ##1 req_ready;
    endsequence

    sequence stall2_s;
        !req_ready [*2] ##1 req_ready;
    endsequence

    reg_route_a: assert property (take && !acc_err && (eff_addr <= DSD_REG_HI)
        |=> rsp.valid && (rsp.tgt == DSD_TGT_REG)) else $error("register file not selected");
    io_route_a: assert property (take && (eff_addr >= DSD_IO_LO) && (eff_addr <= DSD_IO_HI)
        && !acc_err |=> rsp.tgt == DSD_TGT_IO) else $error("standard I/O not selected");
    ext_route_a: assert property (take && !acc_err && (eff_addr >= DSD_EXT_LO)
        && (eff_addr <= DSD_EXT_HI) |=> rsp.tgt == DSD_TGT_EXT) else $error("ext I/O missed");
    sram_route_a: assert property (take && !acc_err && sram_hit
        |-> ##2 rsp.tgt == DSD_TGT_SRAM) else $error("SRAM not selected");
    io_ext_a: assert property (take && is_io_op |-> eff_addr <= DSD_IO_HI)
        else $error("I/O op reached extended I/O");
    io_offset_a: assert property (io_bus.valid && is_io_op
        |-> io_bus.addr == (8'(req.io_addr) + 8'h20)) else $error("I/O offset wrong");
    bit_range_a: assert property (take && is_bit_op && (req.io_addr > DSD_IO_BIT_HI)
        |=> rsp.valid && rsp.err) else $error("bit op above 0x1F accepted");
    bit_only_a: assert property (take && (req.op == DSD_OP_BIT_SET) && gpio_hit[0]
        |=> s_r.gpio[0] == ($past(s_r.gpio[0]) | (8'h01 << $past(req.bit_idx))))
        else $error("bit set touched other bits");
    flag_w1c_a: assert property (wr_ok && flag_hit && (req.op == DSD_OP_STORE)
        && (flag_set_in == 8'h00) |=> (s_r.flags & $past(req.wdata)) == 8'h00)
        else $error("flag not cleared by one");
    sram_lat_a: assert property (sram_go |=> sram_wait_s)
        else $error("SRAM access not two cycles");
    post_inc_a: assert property (take && !acc_err && (req.mode == DSD_AM_POSTINC)
        && !is_io_op |=> {s_r.regs[$past(ptr_hi)], s_r.regs[$past(ptr_lo)]}
        == ($past(ptr_val) + 16'h0001)) else $error("post-increment wrong");
    pre_dec_a: assert property (take && !acc_err && (req.mode == DSD_AM_PREDEC)
        && !is_io_op |=> {s_r.regs[$past(ptr_hi)], s_r.regs[$past(ptr_lo)]}
        == ($past(ptr_val) - 16'h0001)) else $error("pre-decrement wrong");
    none_sel_a: assert property (take && !acc_err && !sram_hit && (eff_addr > DSD_EXT_HI)
        |=> rsp.valid && (rsp.tgt == DSD_TGT_NONE) && (rsp.data == 8'h00))
        else $error("unmapped address answered");
    ee_rd_a: assert property (take && ee_rd_trig |=> stall4_s)
        else $error("EEPROM read stall not four");
    ee_wr_a: assert property (take && ee_wr_trig && !ee_rd_trig |=> stall2_s)
        else $error("EEPROM write stall not two");

endmodule

// ==== verification/dsd_periph_model.sv ====
// Peripheral model holding the external I/O registers behind the decoder.
`timescale 1ns/1ps
module dsd_periph_model import dsd_pkg::*; (
    input  wire logic    clock,
    input  wire dsd_io_t io_bus,
    output logic [7:0]   io_rdata
);
    logic [7:0] mem [256];
    logic [7:0] last_r = 8'h00;

    // Start from a known state so that a read never returns an unknown value.
    initial foreach (mem[i]) mem[i] = 8'h00;

    // Outside a transfer the read lines show the inverse of the last byte.
    // A decoder that samples late then sees a wrong value, not a stale copy of the right one.
    assign io_rdata = io_bus.valid ? mem[io_bus.addr] : ~last_r;

    // A write changes only the bit lanes named in the mask.
    always @(posedge clock) begin
        if (io_bus.valid === 1'b1) begin
            last_r <= mem[io_bus.addr];
            if (io_bus.we) mem[io_bus.addr] <= (mem[io_bus.addr] & ~io_bus.wmask) |
                                               (io_bus.wdata & io_bus.wmask);
        end
    end
endmodule

// ==== verification/dsd_decoder_tb.sv ====
// Self-checking bench for the data-space address decoder.
`timescale 1ns/1ps
module dsd_decoder_tb import dsd_pkg::*; ();
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    dsd_req_t    req = '0;
    logic        req_ready, ee_rs, ee_ws;
    dsd_rsp_t    rsp;
    dsd_io_t     io_bus;
    logic [7:0]  io_rdata, v;
    logic [7:0]  flag_set_in = 8'h00;
    logic [13:0] q[$];
    logic [13:0] e;
    logic [31:0] s = 32'h5ef7;
    int          num_errors = 0, check_count = 0, n;
    logic [15:0] ta[6] = '{16'h001F, 16'h005F, 16'h0060, 16'h0100, 16'h04FF, 16'h0500};
    logic [4:0]  tt[6] = '{DSD_TGT_REG, DSD_TGT_IO, DSD_TGT_EXT, DSD_TGT_SRAM,
                           DSD_TGT_SRAM, DSD_TGT_NONE};

    // A small SRAM puts the top boundary and the empty region within reach.
    dsd_decoder #(.SRAM_BYTES(1024)) dut_u (.clock(clock), .rst_n(rst_n), .req(req),
        .req_ready(req_ready), .rsp(rsp), .io_bus(io_bus), .io_rdata(io_rdata),
        .flag_set_in(flag_set_in), .ee_read_strobe(ee_rs), .ee_write_strobe(ee_ws));
    dsd_periph_model per_u (.clock(clock), .io_bus(io_bus), .io_rdata(io_rdata));

    always #2.5 clock = ~clock;

    function automatic logic [7:0] xs();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s[7:0];
    endfunction

    task automatic chk(string nm, logic [15:0] x, logic [15:0] g);
        check_count++;
        if (x !== g) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Counts the cycles that the decoder refuses new work after a take.
    task automatic stall(int x);
        for (n = 0; req_ready !== 1'b1 && n < 20; n++) @(negedge clock);
        chk("stall", 16'(x), 16'(n));
    endtask

    // One request held across its take edge; ed[8] set means the data is not checked.
    task automatic go(dsd_op_t o, logic [15:0] a, logic [8:0] ed, logic [4:0] et);
        @(negedge clock);
        for (n = 0; req_ready !== 1'b1 && n < 20; n++) @(negedge clock);
        req.op = o;
        req.addr = a;
        req.io_addr = a[5:0];
        req.wdata = v;
        req.valid = 1'b1;
        q.push_back({ed, et});
        @(negedge clock);
        req.valid = 1'b0;
    endtask

    // Each answer is matched against the oldest note left by the driver.
    always @(negedge clock) begin
        if (rsp.valid === 1'b1) begin
            e = (q.size() > 0) ? q.pop_front() : 14'h3FFF;
            chk("tgt", 16'(e[4:0]), 16'(rsp.tgt));
            if (!e[13]) chk("data", 16'(e[12:5]), 16'(rsp.data));
        end
    end

    initial begin
        #50000;
        num_errors++;
        final_report;
    end

    initial begin
        repeat (20) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        foreach (ta[i]) begin
            v = xs();
            go(DSD_OP_STORE, ta[i], 9'h100, tt[i]);
            stall(tt[i] == DSD_TGT_SRAM);
            go(DSD_OP_LOAD, ta[i], {1'b0, (i == 5) ? 8'h00 : v}, tt[i]);
            stall(tt[i] == DSD_TGT_SRAM);
        end
        v = xs();
        go(DSD_OP_IO_OUT, 16'h002A, 9'h100, DSD_TGT_IO);
        go(DSD_OP_LOAD, 16'h004A, {1'b0, v}, DSD_TGT_IO);
        v = 8'h5A;
        go(DSD_OP_STORE, 16'h003E, 9'h100, DSD_TGT_IO);
        req.bit_idx = 3'h0;
        go(DSD_OP_BIT_SET, 16'h001E, 9'h100, DSD_TGT_IO);
        req.bit_idx = 3'h6;
        go(DSD_OP_BIT_CLR, 16'h001E, 9'h100, DSD_TGT_IO);
        req.bit_idx = 3'h4;
        go(DSD_OP_BIT_TEST, 16'h001E, 9'h01B, DSD_TGT_IO);
        chk("bit_state", 16'h0001, 16'(rsp.bit_state));
        go(DSD_OP_BIT_SET, 16'h0020, 9'h000, DSD_TGT_NONE);
        chk("err", 16'h0001, 16'(rsp.err));
        // A peripheral register takes a byte, then one bit, and reads back both ways.
        v = 8'hA5;
        go(DSD_OP_IO_OUT, 16'h0010, 9'h100, DSD_TGT_IO);
        req.bit_idx = 3'h1;
        go(DSD_OP_BIT_SET, 16'h0010, 9'h100, DSD_TGT_IO);
        go(DSD_OP_IO_IN, 16'h0010, 9'h0A7, DSD_TGT_IO);
        go(DSD_OP_LOAD, 16'h0030, 9'h0A7, DSD_TGT_IO);
        flag_set_in = 8'h0C;
        @(negedge clock) flag_set_in = 8'h00;
        v = 8'h04;
        go(DSD_OP_STORE, 16'h0036, 9'h100, DSD_TGT_IO);
        go(DSD_OP_LOAD, 16'h0036, 9'h008, DSD_TGT_IO);
        req.bit_idx = 3'h3;
        go(DSD_OP_BIT_SET, 16'h0016, 9'h100, DSD_TGT_IO);
        go(DSD_OP_LOAD, 16'h0036, 9'h000, DSD_TGT_IO);
        v = 8'h01;
        go(DSD_OP_STORE, 16'h003F, 9'h100, DSD_TGT_IO);
        chk("ee_strobes", 16'h0002, 16'({ee_rs, ee_ws}));
        stall(4);
        v = 8'h02;
        go(DSD_OP_STORE, 16'h003F, 9'h100, DSD_TGT_IO);
        chk("ee_strobes", 16'h0001, 16'({ee_rs, ee_ws}));
        stall(2);
        // Pointer Y holds 0x0100 and pointer X the SRAM byte 0x013F.
        v = 8'h00;
        go(DSD_OP_STORE, 16'h001C, 9'h100, DSD_TGT_REG);
        v = 8'h3F;
        go(DSD_OP_STORE, 16'h001A, 9'h100, DSD_TGT_REG);
        v = 8'h01;
        go(DSD_OP_STORE, 16'h001D, 9'h100, DSD_TGT_REG);
        go(DSD_OP_STORE, 16'h001B, 9'h100, DSD_TGT_REG);
        v = xs();
        go(DSD_OP_STORE, 16'h013F, 9'h100, DSD_TGT_SRAM);
        {req.mode, req.ptr, req.disp} = {DSD_AM_DISP, DSD_PTR_Y, 6'h3F};
        // Y base 0x0100 plus displacement 63 reaches 0x013F.
        go(DSD_OP_LOAD, 16'h0000, {1'b0, s[7:0]}, DSD_TGT_SRAM);
        req.ptr = DSD_PTR_X;
        go(DSD_OP_LOAD, 16'h0000, 9'h000, DSD_TGT_NONE);
        {req.mode, req.disp} = {DSD_AM_POSTINC, 6'h00};
        go(DSD_OP_LOAD, 16'h0000, {1'b0, s[7:0]}, DSD_TGT_SRAM);
        req.mode = DSD_AM_DIRECT;
        go(DSD_OP_LOAD, 16'h001A, 9'h040, DSD_TGT_REG);
        // Pre-decrement brings X back to 0x013F; plain indirect leaves it there.
        req.mode = DSD_AM_PREDEC;
        go(DSD_OP_LOAD, 16'h0000, {1'b0, s[7:0]}, DSD_TGT_SRAM);
        req.mode = DSD_AM_IND;
        go(DSD_OP_LOAD, 16'h0000, {1'b0, s[7:0]}, DSD_TGT_SRAM);
        req.mode = DSD_AM_DIRECT;
        go(DSD_OP_LOAD, 16'h001A, 9'h03F, DSD_TGT_REG);
        repeat (4) @(negedge clock);
        chk("pending", 16'h0000, 16'(q.size()));
        final_report;
    end
endmodule
